// [opc_params.svh]
// constants for the output analog loop configuration register bank
`ifndef OPC_PARAMS_SVH
`define OPC_PARAMS_SVH
// register indices as printed; byte address is four times the index
`define OPC_IDX_CP_CURRENT 12'h430
`define OPC_IDX_FB_DIVIDE 12'h431
`define OPC_IDX_LOOP_FILTER 12'h432
`define OPC_IDX_DIV_CTRL 12'h433
// field positions
`define OPC_CP_MSB 6
`define OPC_LF_RP2_MSB 7
`define OPC_LF_RP2_LSB 6
`define OPC_LF_RZ_MSB 5
`define OPC_LF_RZ_LSB 3
`define OPC_LF_CP1_MSB 2
`define OPC_LF_CP1_LSB 0
`define OPC_CTRL_BYPASS_BIT 0
`define OPC_CTRL_PDIV_RST_BIT 1
// reset values
`define OPC_RST_CP_CURRENT 8'h2E
`define OPC_RST_FB_DIVIDE 8'h00
`define OPC_RST_LOOP_FILTER 8'h7F
`define OPC_RST_DIV_CTRL 8'h00
// writable bit masks, reserved bits read zero
`define OPC_MASK_CP_CURRENT 8'h7F
`define OPC_MASK_FB_DIVIDE 8'hFF
`define OPC_MASK_LOOP_FILTER 8'hFF
`define OPC_MASK_DIV_CTRL 8'h03
// supported feedback divide range
`define OPC_FB_MIN 8'h0E
`define OPC_FB_MAX 8'hFF
`endif

// [opc_pkg.sv]
// types for the output analog loop configuration register bank
package opc_pkg;
   typedef logic [7:0] opc_byte_t;
   typedef logic [1:0] opc_rp2_t;
   typedef logic [2:0] opc_rz_t;
   typedef logic [2:0] opc_cp1_t;
   typedef logic [1:0] opc_sel_t;
   // access phases of the bus slave, one-hot
   typedef enum logic [1:0] {
      OPC_IDLE = 2'b01,
      OPC_ACCESS = 2'b10
   } opc_state_t;
endpackage

// [opc_reg_bank.sv]
// four-byte register store with registered read data
`timescale 1ns/10ps
`include "opc_params.svh"
module opc_reg_bank (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // write port
   input wire logic wr_en_i,
   input wire opc_pkg::opc_sel_t wr_sel_i,
   input wire opc_pkg::opc_byte_t wr_data_i,
   // read port
   input wire opc_pkg::opc_sel_t rd_sel_i,
   output opc_pkg::opc_byte_t rd_data_o,
   // current contents
   output opc_pkg::opc_byte_t cp_current_o,
   output opc_pkg::opc_byte_t fb_divide_o,
   output opc_pkg::opc_byte_t loop_filter_o,
   output opc_pkg::opc_byte_t div_ctrl_o
);
   import opc_pkg::*;

   opc_byte_t regs [4];
   localparam opc_byte_t rst_val [4] = '{`OPC_RST_CP_CURRENT, `OPC_RST_FB_DIVIDE,
      `OPC_RST_LOOP_FILTER, `OPC_RST_DIV_CTRL};
   localparam opc_byte_t mask_val [4] = '{`OPC_MASK_CP_CURRENT, `OPC_MASK_FB_DIVIDE,
      `OPC_MASK_LOOP_FILTER, `OPC_MASK_DIV_CTRL};

   // one storage byte per register; masking keeps reserved bits at zero
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_reg
         always_ff @(posedge ref_clk_i) begin
            if (!resetn_i) begin
               regs[gi] <= rst_val[gi];
            end else if (wr_en_i && wr_sel_i == 2'(gi)) begin
               regs[gi] <= wr_data_i & mask_val[gi];
            end
         end
      end
   endgenerate

   // read data registered so the bus sees a stable byte in the access phase
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) begin
         rd_data_o <= 8'h00;
      end else begin
         rd_data_o <= regs[rd_sel_i];
      end
   end

   assign cp_current_o = regs[0];
   assign fb_divide_o = regs[1];
   assign loop_filter_o = regs[2];
   assign div_ctrl_o = regs[3];
endmodule

// [opc_output_loop_cfg.sv]
// apb register bank configuring the output analog loop and its post divider
// Notes on behaviour
// [RULE_01] seven-bit pump current, resets to 0x2E
// [RULE_02] eight-bit feedback divide; software keeps 14..255
// [RULE_03] top two bits pick second pole resistor
// [RULE_04] middle three bits pick zero resistor
// [RULE_05] low three bits pick first pole capacitor
// [RULE_06] control bit 1 holds post divider reset
// [RULE_07] control bit 0 bypasses internal zero resistor
// [RULE_08] registers read back, reserved bits zero
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
`include "opc_params.svh"
module opc_output_loop_cfg (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [15:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // analog loop settings
   output logic [6:0] pump_current_code_o,
   output opc_pkg::opc_byte_t feedback_divider_o,
   output opc_pkg::opc_rp2_t second_pole_resistor_o,
   output opc_pkg::opc_rz_t zero_resistor_o,
   output opc_pkg::opc_cp1_t first_pole_capacitor_o,
   output logic zero_resistor_bypass_o,
   output logic post_vco_divider_reset_o,
   // decoded values for monitoring
   output logic [10:0] zero_resistor_ohms_o,
   output logic [9:0] second_pole_resistor_ohms_o,
   output logic [7:0] first_pole_capacitor_pf_o,
   output logic feedback_divide_legal_o
);
   import opc_pkg::*;

   opc_state_t state;
   opc_state_t next_state;
   opc_byte_t cp_q;
   opc_byte_t fb_q;
   opc_byte_t lf_q;
   opc_byte_t ctrl_q;
   opc_byte_t rd_byte;
   logic hit;
   logic err_q;
   logic wr_en;
   opc_sel_t sel;
   logic [2:0] dec;

   // map a byte address onto one of the four registers
   function automatic logic [2:0] decode(input logic [15:0] a);
      logic [13:0] idx;
      idx = a[15:2];
      decode = 3'b000;
      if (a[1:0] == 2'b00) begin
         if (idx == 14'(`OPC_IDX_CP_CURRENT)) decode = 3'b100;
         else if (idx == 14'(`OPC_IDX_FB_DIVIDE)) decode = 3'b101;
         else if (idx == 14'(`OPC_IDX_LOOP_FILTER)) decode = 3'b110;
         else if (idx == 14'(`OPC_IDX_DIV_CTRL)) decode = 3'b111;
      end
   endfunction

   // one decode shared by the error flag, the write enable and the read select
   assign dec = decode(paddr_i);
   assign hit = dec[2];
   assign sel = dec[1:0];

   // setup cycle loads read data; access phase answers one cycle later
   always_comb begin
      next_state = state;
      case (state)
         OPC_IDLE: begin
            if (psel_i && !penable_i) next_state = OPC_ACCESS;
         end
         OPC_ACCESS: begin
            next_state = OPC_IDLE;
         end
         default: next_state = OPC_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) state <= OPC_IDLE;
      else state <= next_state;
   end

   // error is latched in setup so it matches the address of the access
   always_ff @(posedge ref_clk_i) begin
      if (!resetn_i) err_q <= 1'b0;
      else if (psel_i && !penable_i) err_q <= !hit;
   end

   assign pready_o = (state == OPC_ACCESS);
   assign pslverr_o = pready_o && err_q;
   // write lands only on the completing edge; lane 0 holds the byte
   assign wr_en = psel_i && penable_i && pready_o && pwrite_i && hit && pstrb_i[0];
   // [RULE_08] read back masked
   assign prdata_o = (pready_o && !err_q) ? {24'h000000, rd_byte} : 32'h00000000;

   // [RULE_08] storage with readback
   opc_reg_bank u_bank (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .wr_en_i(wr_en),
      .wr_sel_i(sel),
      .wr_data_i(pwdata_i[7:0]),
      .rd_sel_i(sel),
      .rd_data_o(rd_byte),
      .cp_current_o(cp_q),
      .fb_divide_o(fb_q),
      .loop_filter_o(lf_q),
      .div_ctrl_o(ctrl_q)
   );

   // [RULE_01] pump current code
   assign pump_current_code_o = cp_q[`OPC_CP_MSB:0];
   // [RULE_02] divide ratio, range flagged
   assign feedback_divider_o = fb_q;
   assign feedback_divide_legal_o = (fb_q >= `OPC_FB_MIN) && (fb_q <= `OPC_FB_MAX);
   // [RULE_03] second pole field
   assign second_pole_resistor_o = lf_q[`OPC_LF_RP2_MSB:`OPC_LF_RP2_LSB];
   // [RULE_04] zero resistor field
   assign zero_resistor_o = lf_q[`OPC_LF_RZ_MSB:`OPC_LF_RZ_LSB];
   // [RULE_05] first pole field
   assign first_pole_capacitor_o = lf_q[`OPC_LF_CP1_MSB:`OPC_LF_CP1_LSB];
   // [RULE_06] post divider hold
   assign post_vco_divider_reset_o = ctrl_q[`OPC_CTRL_PDIV_RST_BIT];
   // [RULE_07] zero resistor bypass
   assign zero_resistor_bypass_o = ctrl_q[`OPC_CTRL_BYPASS_BIT];

   // value decode; bypass forces zero ohms since the board then supplies it
   always_comb begin
      case (second_pole_resistor_o)
         2'h0: second_pole_resistor_ohms_o = 10'd500;
         2'h1: second_pole_resistor_ohms_o = 10'd333;
         2'h2: second_pole_resistor_ohms_o = 10'd250;
         default: second_pole_resistor_ohms_o = 10'd200;
      endcase
      case (zero_resistor_o)
         3'h0: zero_resistor_ohms_o = 11'd1500;
         3'h1: zero_resistor_ohms_o = 11'd1250;
         3'h2: zero_resistor_ohms_o = 11'd1000;
         3'h3: zero_resistor_ohms_o = 11'd930;
         3'h4: zero_resistor_ohms_o = 11'd1250;
         3'h5: zero_resistor_ohms_o = 11'd1000;
         3'h6: zero_resistor_ohms_o = 11'd750;
         default: zero_resistor_ohms_o = 11'd680;
      endcase
      if (zero_resistor_bypass_o) zero_resistor_ohms_o = 11'd0;
      case (first_pole_capacitor_o)
         3'h0: first_pole_capacitor_pf_o = 8'd10;
         3'h1: first_pole_capacitor_pf_o = 8'd30;
         3'h2: first_pole_capacitor_pf_o = 8'd40;
         3'h3: first_pole_capacitor_pf_o = 8'd70;
         3'h4: first_pole_capacitor_pf_o = 8'd90;
         3'h5: first_pole_capacitor_pf_o = 8'd110;
         3'h6: first_pole_capacitor_pf_o = 8'd130;
         default: first_pole_capacitor_pf_o = 8'd150;
      endcase
   end

   sequence s_setup;
      psel_i && !penable_i;
   endsequence
   sequence s_access;
      psel_i && penable_i && pready_o;
   endsequence

   a_answer_one_cycle: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RULE_08]
      s_setup |=> pready_o) else $error("no answer one cycle after setup");
   a_pump_reserved_zero: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RULE_01]
      cp_q[7] == 1'b0) else $error("pump current reserved bit set");
   a_pump_after_reset: assert property (@(posedge ref_clk_i) // [RULE_01]
      !resetn_i |=> pump_current_code_o == 7'h2E) else $error("pump current reset wrong");
   a_fb_write: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RULE_02]
      (s_access and (pwrite_i && !err_q && pstrb_i[0] && sel == 2'h1))
      |=> feedback_divider_o == $past(pwdata_i[7:0])) else $error("divide write lost");
   a_fb_legal: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RULE_02]
      feedback_divide_legal_o == (fb_q > 8'd13)) else $error("divide range flag wrong");
   a_rp2_decode: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RULE_03]
      lf_q[7:6] == 2'h1 |-> second_pole_resistor_ohms_o == 10'd333)
      else $error("second pole decode wrong");
   a_rz_decode: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RULE_04]
      (lf_q[5:3] == 3'h3 && !ctrl_q[0]) |-> zero_resistor_ohms_o == 11'd930)
      else $error("zero resistor decode wrong");
   a_cp1_decode: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RULE_05]
      lf_q[2:0] == 3'h0 |-> first_pole_capacitor_pf_o == 8'd10)
      else $error("first pole decode wrong");
   a_pdiv_reset: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RULE_06]
      (s_access and (pwrite_i && !err_q && pstrb_i[0] && sel == 2'h3))
      |=> post_vco_divider_reset_o == $past(pwdata_i[1])) else $error("divider hold wrong");
   a_bypass_zero: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RULE_07]
      zero_resistor_bypass_o |-> zero_resistor_ohms_o == 11'd0) else $error("bypass not zero");
   a_ctrl_reserved: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RULE_08]
      ctrl_q[7:2] == 6'h00) else $error("control reserved bits set");

   // a refused or unstrobed write must leave every register as it was
   sequence s_ignored_write;
      psel_i && penable_i && pready_o && pwrite_i && (err_q || !pstrb_i[0]);
   endsequence

   // bus handshake checks; the error must follow the address of the access
   a_ready_single: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RULE_08]
      pready_o |=> !pready_o) else $error("ready held past one cycle");
   a_rdata_idle_zero: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RULE_08]
      !pready_o |-> prdata_o == 32'h00000000) else $error("read data outside access");
   a_error_answer: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RULE_08]
      s_access |-> pslverr_o == !hit) else $error("error answer wrong");
   a_ignored_write: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RULE_08]
      s_ignored_write |=> $stable(cp_q) && $stable(fb_q) && $stable(lf_q) && $stable(ctrl_q))
      else $error("refused write changed a register");
   a_loop_readback: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RULE_08]
      (s_access and (!pwrite_i && !err_q && sel == 2'h2)) |-> prdata_o == {24'h000000, lf_q})
      else $error("loop filter readback wrong");

   // reset values seen one edge after reset is sampled
   a_fb_after_reset: assert property (@(posedge ref_clk_i) // [RULE_02]
      !resetn_i |=> feedback_divider_o == 8'h00) else $error("divide reset wrong");
   a_lf_after_reset: assert property (@(posedge ref_clk_i) // [RULE_04]
      !resetn_i |=> lf_q == 8'h7F) else $error("loop filter reset wrong");
   a_ctrl_after_reset: assert property (@(posedge ref_clk_i) // [RULE_06]
      !resetn_i |=> !post_vco_divider_reset_o && !zero_resistor_bypass_o)
      else $error("control reset wrong");
endmodule

// [opc_output_loop_cfg_tb_top.sv]
// self-checking bench for the output analog loop configuration bank
`timescale 1ns/10ps
module opc_output_loop_cfg_tb_top;
   import opc_pkg::*;
   typedef struct {logic [15:0] a; logic [7:0] w; logic [7:0] e;} opc_row_t;
   logic ref_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata, rdv;
   logic pready, pslverr, byp, prst, legal, erv;
   logic [6:0] pump;
   opc_byte_t fbd;
   opc_rp2_t rp2;
   opc_rz_t rz;
   opc_cp1_t cp1;
   logic [10:0] rz_ohm;
   logic [9:0] rp2_ohm;
   logic [7:0] cp1_pf;
   int checks = 0;
   int failures = 0;
   // decode tables and ordinary write/readback rows; reserved bits read back as zero
   logic [10:0] rz_tab [8] = '{11'h5DC, 11'h4E2, 11'h3E8, 11'h3A2,
      11'h4E2, 11'h3E8, 11'h2EE, 11'h2A8};
   logic [7:0] cp_tab [8] = '{8'h0A, 8'h1E, 8'h28, 8'h46, 8'h5A, 8'h6E, 8'h82, 8'h96};
   logic [9:0] rp_tab [4] = '{10'h1F4, 10'h14D, 10'h0FA, 10'h0C8};
   opc_row_t rows [6] = '{'{16'h10C0, 8'hFF, 8'h7F}, '{16'h10C0, 8'h00, 8'h00},
      '{16'h10C4, 8'hFF, 8'hFF}, '{16'h10C4, 8'h0D, 8'h0D}, '{16'h10C8, 8'hA5, 8'hA5},
      '{16'h10CC, 8'hFF, 8'h03}};

   opc_output_loop_cfg opc_output_loop_cfg_i (
      .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .pump_current_code_o(pump), .feedback_divider_o(fbd), .second_pole_resistor_o(rp2),
      .zero_resistor_o(rz), .first_pole_capacitor_o(cp1), .zero_resistor_bypass_o(byp),
      .post_vco_divider_reset_o(prst), .zero_resistor_ohms_o(rz_ohm),
      .second_pole_resistor_ohms_o(rp2_ohm), .first_pole_capacitor_pf_o(cp1_pf),
      .feedback_divide_legal_o(legal));

   // 40 MHz clock
   initial begin
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end

   task automatic summarize;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   // one apb transfer; waits for pready under a bound, then lets the edge settle
   task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d, input logic s);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      pstrb <= {3'h0, s};
      @(posedge ref_clk_i);
      pen <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         failures++;
         summarize();
      end
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      #1;
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      apb(1'b1, a, d, 1'b1);
   endtask

   task automatic rdc(input logic [15:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00, 1'b1);
      chk(rdv, {24'h000000, e});
   endtask

   // main sequence: reset values, table rows, then the awkward cases
   initial begin
      repeat (8) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      rdc(16'h10C0, 8'h2E);
      rdc(16'h10C4, 8'h00);
      rdc(16'h10C8, 8'h7F);
      rdc(16'h10CC, 8'h00);
      chk({byp, prst, pump}, 9'h02E);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rdc(rows[i].a, rows[i].e);
      end
      chk({legal, pump, fbd, rp2, rz, cp1}, {1'b0, 7'h00, 8'h0D, 2'h2, 3'h4, 3'h5});
      chk({byp, prst}, 2'h3);
      wr(16'h10C4, 8'h0E);
      chk(legal, 1'b1);
      // every resistor and capacitor code, internal zero resistor in use
      wr(16'h10CC, 8'h00);
      for (int i = 0; i < 8; i++) begin
         wr(16'h10C8, {i[1:0], i[2:0], i[2:0]});
         chk(rz_ohm, rz_tab[i]);
         chk(cp1_pf, cp_tab[i]);
         chk(rp2_ohm, rp_tab[i % 4]);
      end
      wr(16'h10CC, 8'h01);
      chk({rz_ohm, byp, prst}, 13'h0002);
      wr(16'h10CC, 8'h02);
      chk({byp, prst}, 2'h1);
      // strobe off, unmapped and misaligned places are refused
      apb(1'b1, 16'h10C4, 8'h55, 1'b0);
      rdc(16'h10C4, 8'h0E);
      apb(1'b1, 16'h10D0, 8'hFF, 1'b1);
      chk(rdv, 32'h00000000);
      chk(erv, 1'b1);
      apb(1'b0, 16'h10C1, 8'h00, 1'b1);
      chk(erv, 1'b1);
      // second reset in mid-run restores defaults
      @(posedge ref_clk_i);
      resetn_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      rdc(16'h10C0, 8'h2E);
      rdc(16'h10C8, 8'h7F);
      rdc(16'h10CC, 8'h00);
      summarize();
   end
endmodule
